// File: rbw_pkg.sv
// Behaviour
// RQ1 - Combined request writes all before reading.
// RQ2 - Client orders combined fields read, write, count.
// RQ3 - Read quantity must be one to sixteen.
// RQ4 - Write quantity 1-16, byte count twice it.
// RQ5 - Two-byte fields travel high byte first.
// RQ6 - Combined success: unit, code, count, read words.
// RQ7 - Combined failure answers error code 97h.
// RQ8 - Write-multiple failure answers error code 90h.
// RQ9 - Bad register number gives exception 02h.
// RQ10 - Network register address plus one is used.
// RQ11 - Write-multiple success echoes start and quantity; the code echoes the start plus one, then the quantity.
// RQ12 - Write-multiple quantity 1-16, byte count twice.
// RQ13 - Bad byte count rejected, nothing written.
// RQ14 - Unit identifier copied into every response.
`default_nettype none
package rbw_pkg;

  // **************************************************************
  // Function and error codes.
  // **************************************************************
  localparam logic [7:0] RBW_FC_WR_MULTI = 8'h10;  // Write multiple registers.
  localparam logic [7:0] RBW_FC_RW_MULTI = 8'h17;  // Combined read/write.
  localparam logic [7:0] RBW_ERR_FLAG    = 8'h80;  // Or-ed into the code on failure.
  localparam logic [7:0] RBW_EXC_ADDR    = 8'h02;  // Register number invalid.
  localparam logic [7:0] RBW_EXC_VALUE   = 8'h03;  // Quantity or length invalid.

  // **************************************************************
  // Request layout: byte positions within the frame.
  // **************************************************************
  localparam logic [7:0] RBW_POS_UNIT  = 8'h00;  // Unit identifier.
  localparam logic [7:0] RBW_POS_FC    = 8'h01;  // Function code.
  localparam logic [7:0] RBW_POS_F1    = 8'h02;  // First two-byte field.
  localparam logic [7:0] RBW_POS_F2    = 8'h04;  // Second two-byte field.
  localparam logic [7:0] RBW_POS_F3    = 8'h06;  // Third two-byte field.
  localparam logic [7:0] RBW_POS_F4    = 8'h08;  // Fourth two-byte field.
  localparam logic [7:0] RBW_POS_BC10  = 8'h06;  // Byte count, write multiple.
  localparam logic [7:0] RBW_POS_BC17  = 8'h0a;  // Byte count, combined.
  localparam logic [7:0] RBW_BASE10    = 8'h07;  // First value byte, write multiple.
  localparam logic [7:0] RBW_BASE17    = 8'h0b;  // First value byte, combined.

  // **************************************************************
  // Limits, response lengths and reset values.
  // **************************************************************
  localparam logic [15:0] RBW_QTY_MIN   = 16'h0001;  // Fewest registers per request.
  localparam logic [15:0] RBW_QTY_MAX   = 16'h0010;  // Most registers per request.
  localparam logic [5:0]  RBW_LEN_ERR   = 6'h03;     // Error response length.
  localparam logic [5:0]  RBW_LEN_WR_OK = 6'h06;     // Write-multiple response length.
  localparam logic [5:0]  RBW_LEN_HDR   = 6'h03;     // Combined response header length.
  localparam logic [15:0] RBW_RST_WORD  = 16'h0000;  // Reset value of field registers.
  localparam logic [7:0]  RBW_RST_BYTE  = 8'h00;     // Reset value of byte registers.

endpackage : rbw_pkg
`default_nettype wire

// File: rbw_word_buf.sv
`timescale 1ns/1ps
`default_nettype none
// **************************************************************
// Small word store shared by write values and read results.
// **************************************************************
module rbw_word_buf #(
  parameter int W     = 16,  // Word width.
  parameter int DEPTH = 16,  // Number of words.
  parameter int AW    = 4    // Index width.
) (
  input  wire logic          clk_in,      // System clock.
  input  wire logic          wr_en_in,    // Store strobe.
  input  wire logic [AW-1:0] wr_idx_in,   // Store index.
  input  wire logic [W-1:0]  wr_data_in,  // Store data.
  input  wire logic [AW-1:0] rd_idx_in,   // Fetch index.
  output logic      [W-1:0]  rd_data_out  // Fetched word.
);

  logic [W-1:0] mem [DEPTH];  // Storage array; contents are don't-care after reset.

  // Writes land on the clock edge.
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  // Reads are asynchronous so the caller sees the word in the same cycle.
  assign rd_data_out = mem[rd_idx_in];

endmodule : rbw_word_buf
`default_nettype wire

// File: rbw_span_chk.sv
`timescale 1ns/1ps
`default_nettype none
// **************************************************************
// Checks that a block of holding registers lies inside the map.
// **************************************************************
module rbw_span_chk #(
  parameter logic [15:0] FIRST = 16'h0001,  // Lowest holding register present.
  parameter logic [15:0] LAST  = 16'h0fff   // Highest holding register present.
) (
  input  wire logic [15:0] start_in,  // Network start address, zero based.
  input  wire logic [15:0] qty_in,    // Number of registers.
  output logic             ok_out     // High when every register exists.
);

  logic [16:0] first_hold;  // First holding register, one based.
  logic [16:0] last_hold;   // Last holding register, one based.

  // The network address is bumped by one before it is judged. [RQ10]
  assign first_hold = {1'b0, start_in} + 17'h00001;
  assign last_hold  = {1'b0, start_in} + {1'b0, qty_in};

  // Seventeen-bit sums keep a wrap past the top from looking valid.
  assign ok_out = (first_hold >= {1'b0, FIRST}) && (last_hold <= {1'b0, LAST});

endmodule : rbw_span_chk
`default_nettype wire

// File: rbw_handler.sv
`timescale 1ns/1ps
`default_nettype none
// **************************************************************
// Request handler for write-multiple and combined read/write.
// **************************************************************
module rbw_handler
  import rbw_pkg::*;
#(
  parameter logic [15:0] REG_FIRST = 16'h0001,  // Lowest holding register present.
  parameter logic [15:0] REG_LAST  = 16'h0fff   // Highest holding register present.
) (
  input  wire logic        clk_in,         // 200 MHz system clock.
  input  wire logic        sys_rst_in,     // Synchronous reset, active high.
  input  wire logic        rx_valid_in,    // Request byte present.
  input  wire logic [7:0]  rx_data_in,     // Request byte.
  input  wire logic        rx_last_in,     // Last byte of the request.
  output logic             rx_ready_out,   // Handler takes request bytes.
  output logic             tx_valid_out,   // Response byte present.
  output logic [7:0]       tx_data_out,    // Response byte.
  output logic             tx_last_out,    // Last byte of the response.
  input  wire logic        tx_ready_in,    // Sink takes the response byte.
  output logic             reg_req_out,    // Register access request.
  output logic             reg_we_out,     // High for write, low for read.
  output logic [15:0]      reg_addr_out,   // Holding register number.
  output logic [15:0]      reg_wdata_out,  // Value to write.
  input  wire logic        reg_ack_in,     // Access done this cycle.
  input  wire logic [15:0] reg_rdata_in    // Value read, valid with ack.
);

  // **************************************************************
  // State and request fields.
  // **************************************************************
  typedef enum logic [2:0] {
    RBW_S_RX    = 3'b000,  // Collect request bytes.
    RBW_S_CHECK = 3'b001,  // Validate the parsed request.
    RBW_S_WRITE = 3'b010,  // Write the supplied values.
    RBW_S_READ  = 3'b011,  // Read the requested registers.
    RBW_S_RESP  = 3'b100,  // Prepare the first response byte.
    RBW_S_TX    = 3'b101   // Send the response.
  } rbw_state_e;

  rbw_state_e  state_r;    // Current state.
  logic [7:0]  unit_r;     // Unit identifier, echoed back.
  logic [7:0]  fc_r;       // Function code.
  logic [15:0] rstart_r;   // Read start, network address.
  logic [15:0] rqty_r;     // Read quantity.
  logic [15:0] wstart_r;   // Write start, network address.
  logic [15:0] wqty_r;     // Write quantity.
  logic [7:0]  bc_r;       // Write byte count.
  logic [7:0]  idx_r;      // Bytes received, saturating.
  logic [7:0]  hi_r;       // High byte of a value in flight.
  logic        err_r;      // Response is an error.
  logic [7:0]  exc_r;      // Exception code.
  logic [4:0]  cnt_r;      // Registers done in this phase.
  logic [15:0] addr_r;     // Register address being accessed.
  logic [5:0]  tidx_r;     // Response byte being offered.
  logic [5:0]  tlen_r;     // Response length.
  logic        tvalid_r;   // Response byte valid.
  logic [7:0]  tdata_r;    // Response byte.

  logic        is17;       // Combined request.
  logic [7:0]  base;       // First value byte of this frame type.
  logic [8:0]  off;        // Offset of the byte into the value field.
  logic        val_byte;   // Current byte belongs to a stored value.
  logic        rx_take;    // Request byte taken this cycle.
  logic        w_ok;       // Write span exists.
  logic        r_ok;       // Read span exists.
  logic        qty_bad;    // Quantity or byte count wrong.
  logic        buf_we;     // Store strobe into the word buffer.
  logic [3:0]  buf_widx;   // Store index.
  logic [15:0] buf_wdata;  // Store data.
  logic [3:0]  buf_ridx;   // Fetch index.
  logic [15:0] buf_rdata;  // Fetched word.
  logic [5:0]  tidx_nxt;   // Next response byte index.
  logic [5:0]  roff;       // Offset of the next response byte into the read words.
  logic [7:0]  tbyte_nxt;  // Next response byte.
  logic        phase_end;  // Last access of the current phase acknowledged.

  assign is17     = (fc_r == RBW_FC_RW_MULTI);
  assign base     = is17 ? RBW_BASE17 : RBW_BASE10;
  assign off      = {1'b0, idx_r} - {1'b0, base};
  assign val_byte = (idx_r >= base) && (off < 9'h020);
  assign rx_take  = (state_r == RBW_S_RX) && rx_valid_in;

  // **************************************************************
  // Span checks and the shared word buffer.
  // **************************************************************
  rbw_span_chk #(.FIRST(REG_FIRST), .LAST(REG_LAST)) u_wchk (
    .start_in (wstart_r),
    .qty_in   (wqty_r),
    .ok_out   (w_ok)
  );

  rbw_span_chk #(.FIRST(REG_FIRST), .LAST(REG_LAST)) u_rchk (
    .start_in (rstart_r),
    .qty_in   (rqty_r),
    .ok_out   (r_ok)
  );

  // Write values fill the buffer on receive; read results reuse it afterwards.
  assign buf_we    = (rx_take && val_byte && off[0]) ||
                     ((state_r == RBW_S_READ) && reg_ack_in);
  assign buf_widx  = (state_r == RBW_S_READ) ? cnt_r[3:0] : off[4:1];
  assign buf_wdata = (state_r == RBW_S_READ) ? reg_rdata_in : {hi_r, rx_data_in};  // [RQ5]
  // Read words start at response byte three, so two bytes share one word. [RQ6]
  assign roff      = tidx_nxt - 6'h03;
  assign buf_ridx  = (state_r == RBW_S_WRITE) ? cnt_r[3:0] : roff[4:1];

  rbw_word_buf #(.W(16), .DEPTH(16), .AW(4)) u_buf (
    .clk_in      (clk_in),
    .wr_en_in    (buf_we),
    .wr_idx_in   (buf_widx),
    .wr_data_in  (buf_wdata),
    .rd_idx_in   (buf_ridx),
    .rd_data_out (buf_rdata)
  );

  // **************************************************************
  // Request parsing.
  // **************************************************************
  // Fields are taken by byte position; the combined layout is read start,
  // read quantity, write start, write quantity, then byte count. [RQ2]
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      unit_r   <= RBW_RST_BYTE;
      fc_r     <= RBW_RST_BYTE;
      rstart_r <= RBW_RST_WORD;
      rqty_r   <= RBW_RST_WORD;
      wstart_r <= RBW_RST_WORD;
      wqty_r   <= RBW_RST_WORD;
      bc_r     <= RBW_RST_BYTE;
      hi_r     <= RBW_RST_BYTE;
      idx_r    <= RBW_RST_BYTE;
    end else if (rx_take) begin
      // Saturate so an overlong frame can never alias a short one.
      idx_r <= rx_last_in ? RBW_RST_BYTE : ((idx_r == 8'hff) ? idx_r : idx_r + 8'h01);
      if (idx_r == RBW_POS_UNIT) begin
        unit_r <= rx_data_in;
      end
      if (idx_r == RBW_POS_FC) begin
        fc_r <= rx_data_in;
      end
      // High byte lands first, low byte second. [RQ5]
      if (is17) begin
        if (idx_r == RBW_POS_F1) rstart_r[15:8] <= rx_data_in;
        if (idx_r == RBW_POS_F1 + 8'h01) rstart_r[7:0] <= rx_data_in;
        if (idx_r == RBW_POS_F2) rqty_r[15:8] <= rx_data_in;
        if (idx_r == RBW_POS_F2 + 8'h01) rqty_r[7:0] <= rx_data_in;
        if (idx_r == RBW_POS_F3) wstart_r[15:8] <= rx_data_in;
        if (idx_r == RBW_POS_F3 + 8'h01) wstart_r[7:0] <= rx_data_in;
        if (idx_r == RBW_POS_F4) wqty_r[15:8] <= rx_data_in;
        if (idx_r == RBW_POS_F4 + 8'h01) wqty_r[7:0] <= rx_data_in;
        if (idx_r == RBW_POS_BC17) bc_r <= rx_data_in;
      end else begin
        if (idx_r == RBW_POS_F1) wstart_r[15:8] <= rx_data_in;
        if (idx_r == RBW_POS_F1 + 8'h01) wstart_r[7:0] <= rx_data_in;
        if (idx_r == RBW_POS_F2) wqty_r[15:8] <= rx_data_in;
        if (idx_r == RBW_POS_F2 + 8'h01) wqty_r[7:0] <= rx_data_in;
        if (idx_r == RBW_POS_BC10) bc_r <= rx_data_in;
      end
      if (val_byte && !off[0]) begin
        hi_r <= rx_data_in;
      end
    end
  end

  // Quantity limits and byte count against quantity; frame length is checked separately. [RQ3] [RQ4] [RQ12]
  assign qty_bad = (wqty_r < RBW_QTY_MIN) || (wqty_r > RBW_QTY_MAX) ||
                   ({8'h00, bc_r} != {wqty_r[14:0], 1'b0}) ||
                   (is17 && ((rqty_r < RBW_QTY_MIN) || (rqty_r > RBW_QTY_MAX)));

  // The received length is checked by counting the bytes in a separate register.
  logic [8:0] len_r;  // Bytes in the completed frame.

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      len_r <= 9'h000;
    end else if (rx_take) begin
      len_r <= {1'b0, idx_r} + 9'h001;
    end
  end

  // **************************************************************
  // Sequencer: check, write, read, respond.
  // **************************************************************
  assign phase_end = reg_ack_in && ({11'h000, cnt_r} + 16'h0001 ==
                     ((state_r == RBW_S_WRITE) ? wqty_r : rqty_r));

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= RBW_S_RX;
      err_r   <= 1'b0;
      exc_r   <= RBW_RST_BYTE;
      cnt_r   <= 5'h00;
      addr_r  <= RBW_RST_WORD;
    end else begin
      case (state_r)
        RBW_S_RX: begin
          if (rx_take && rx_last_in) begin
            state_r <= RBW_S_CHECK;
          end
        end
        RBW_S_CHECK: begin
          cnt_r  <= 5'h00;
          addr_r <= wstart_r + 16'h0001;  // [RQ10]
          if (fc_r != RBW_FC_WR_MULTI && !is17) begin
            // Other function codes belong to other handlers; drop silently.
            state_r <= RBW_S_RX;
          end else if (qty_bad || (len_r != {1'b0, base} + {1'b0, bc_r})) begin
            // Nothing is written when the count disagrees. [RQ13]
            err_r   <= 1'b1;
            exc_r   <= RBW_EXC_VALUE;
            state_r <= RBW_S_RESP;
          end else if (!w_ok || (is17 && !r_ok)) begin
            err_r   <= 1'b1;
            exc_r   <= RBW_EXC_ADDR;  // [RQ9]
            state_r <= RBW_S_RESP;
          end else begin
            err_r   <= 1'b0;
            state_r <= RBW_S_WRITE;
          end
        end
        RBW_S_WRITE: begin
          if (phase_end) begin
            // Reads start only after the last write is acknowledged. [RQ1]
            cnt_r   <= 5'h00;
            addr_r  <= rstart_r + 16'h0001;  // [RQ10]
            state_r <= is17 ? RBW_S_READ : RBW_S_RESP;
          end else if (reg_ack_in) begin
            cnt_r  <= cnt_r + 5'h01;
            addr_r <= addr_r + 16'h0001;
          end
        end
        RBW_S_READ: begin
          if (phase_end) begin
            state_r <= RBW_S_RESP;
          end else if (reg_ack_in) begin
            cnt_r  <= cnt_r + 5'h01;
            addr_r <= addr_r + 16'h0001;
          end
        end
        RBW_S_RESP: begin
          state_r <= RBW_S_TX;
        end
        RBW_S_TX: begin
          if (tx_ready_in && tidx_r == tlen_r - 6'h01) begin
            state_r <= RBW_S_RX;
          end
        end
        default: begin
          state_r <= RBW_S_RX;
        end
      endcase
    end
  end

  // Register port: request held until acknowledged.
  assign reg_req_out   = (state_r == RBW_S_WRITE) || (state_r == RBW_S_READ);
  assign reg_we_out    = (state_r == RBW_S_WRITE);
  assign reg_addr_out  = addr_r;
  assign reg_wdata_out = buf_rdata;
  assign rx_ready_out  = (state_r == RBW_S_RX);

  // **************************************************************
  // Response builder.
  // **************************************************************
  assign tidx_nxt = (state_r == RBW_S_TX) ? tidx_r + 6'h01 : 6'h00;

  // Byte selector for the next response byte.
  always_comb begin
    tbyte_nxt = RBW_RST_BYTE;
    if (tidx_nxt == 6'h00) begin
      tbyte_nxt = unit_r;  // [RQ14]
    end else if (tidx_nxt == 6'h01) begin
      tbyte_nxt = err_r ? (fc_r | RBW_ERR_FLAG) : fc_r;  // [RQ7] [RQ8] [RQ11]
    end else if (err_r) begin
      tbyte_nxt = exc_r;
    end else if (!is17) begin
      // Echo the start as a holding register, then the quantity. [RQ11] [RQ10]
      case (tidx_nxt)
        6'h02:   tbyte_nxt = wstart_r[15:8] + {7'h00, &wstart_r[7:0]};
        6'h03:   tbyte_nxt = wstart_r[7:0] + 8'h01;
        6'h04:   tbyte_nxt = wqty_r[15:8];
        default: tbyte_nxt = wqty_r[7:0];
      endcase
    end else if (tidx_nxt == 6'h02) begin
      tbyte_nxt = {rqty_r[6:0], 1'b0};  // [RQ6]
    end else begin
      tbyte_nxt = tidx_nxt[0] ? buf_rdata[15:8] : buf_rdata[7:0];  // [RQ5] [RQ6]
    end
  end

  // Output stage: a byte stays put until the sink takes it.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tvalid_r <= 1'b0;
      tdata_r  <= RBW_RST_BYTE;
      tidx_r   <= 6'h00;
      tlen_r   <= 6'h00;
    end else if (state_r == RBW_S_RESP) begin
      tvalid_r <= 1'b1;
      tdata_r  <= tbyte_nxt;
      tidx_r   <= 6'h00;
      tlen_r   <= err_r ? RBW_LEN_ERR :
                  (is17 ? RBW_LEN_HDR + {rqty_r[4:0], 1'b0} : RBW_LEN_WR_OK);
    end else if (state_r == RBW_S_TX && tx_ready_in) begin
      if (tidx_r == tlen_r - 6'h01) begin
        tvalid_r <= 1'b0;
      end else begin
        tdata_r <= tbyte_nxt;
        tidx_r  <= tidx_nxt;
      end
    end
  end

  assign tx_valid_out = tvalid_r;
  assign tx_data_out  = tdata_r;
  assign tx_last_out  = tvalid_r && (tidx_r == tlen_r - 6'h01);

  // **************************************************************
  // Assertions.
  // **************************************************************
  property p_wr_before_rd;
    @(posedge clk_in) disable iff (sys_rst_in)
      (reg_req_out && !reg_we_out) |->
        $past(state_r == RBW_S_WRITE, 1) || $past(state_r == RBW_S_READ, 1);
  endproperty
  a_wr_before_rd: assert property (p_wr_before_rd) else $error("read before writes done"); // [RQ1]

  property p_qty_ok;
    @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == RBW_S_WRITE) |->
        (wqty_r >= 16'h0001 && wqty_r <= 16'h0010 && bc_r == {wqty_r[6:0], 1'b0});
  endproperty
  a_qty_ok: assert property (p_qty_ok) else $error("write with bad quantity or count"); // [RQ4]

  property p_rqty_ok;
    @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == RBW_S_READ) |-> (rqty_r >= 16'h0001 && rqty_r <= 16'h0010);
  endproperty
  a_rqty_ok: assert property (p_rqty_ok) else $error("read with bad quantity"); // [RQ3]

  property p_err_no_write;
    @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == RBW_S_CHECK && qty_bad) |=> (!reg_req_out [*2]);
  endproperty
  a_err_no_write: assert property (p_err_no_write) else $error("write after bad count"); // [RQ13]

  property p_addr_plus1;
    @(posedge clk_in) disable iff (sys_rst_in)
      (reg_req_out && reg_we_out) |-> (reg_addr_out == wstart_r + {11'h000, cnt_r} + 16'h0001);
  endproperty
  a_addr_plus1: assert property (p_addr_plus1) else $error("write address not one based"); // [RQ10]

  property p_unit_echo;
    @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == RBW_S_RESP) |=> (tx_valid_out && tx_data_out == unit_r);
  endproperty
  a_unit_echo: assert property (p_unit_echo) else $error("unit identifier not echoed"); // [RQ14]

  property p_err_code;
    @(posedge clk_in) disable iff (sys_rst_in)
      (tx_valid_out && tidx_r == 6'h01 && err_r) |->
        (tx_data_out == (is17 ? 8'h97 : 8'h90)) && tlen_r == 6'h03;
  endproperty
  a_err_code: assert property (p_err_code) else $error("wrong error code"); // [RQ7] [RQ8]

  property p_exc_addr;
    @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == RBW_S_CHECK && !qty_bad && !w_ok && !is17 && fc_r == 8'h10
       && len_r == {1'b0, base} + {1'b0, bc_r}) |=> (err_r && exc_r == 8'h02);
  endproperty
  a_exc_addr: assert property (p_exc_addr) else $error("bad address not reported as 02"); // [RQ9]

  property p_rw_count;
    @(posedge clk_in) disable iff (sys_rst_in)
      (tx_valid_out && tidx_r == 6'h02 && is17 && !err_r) |->
        (tx_data_out == {rqty_r[6:0], 1'b0} && tlen_r == 6'h03 + {rqty_r[4:0], 1'b0});
  endproperty
  a_rw_count: assert property (p_rw_count) else $error("combined byte count wrong"); // [RQ6]

  property p_wr_echo;
    @(posedge clk_in) disable iff (sys_rst_in)
      (tx_valid_out && tidx_r == 6'h01 && !err_r && !is17) |->
        (tx_data_out == 8'h10 && tlen_r == 6'h06);
  endproperty
  a_wr_echo: assert property (p_wr_echo) else $error("write response header wrong"); // [RQ11]

endmodule : rbw_handler
`default_nettype wire

// File: rbw_regs_mdl.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Holding register store that answers the handler's access port.
// ************************************************************
module rbw_regs_mdl #(
  parameter int LAT = 2  // Cycles counted in wait_r before each acknowledge; the first of a run waits as long as each later one.
) (
  input  wire logic        clk_in,     // System clock.
  input  wire logic        req_in,     // Access request.
  input  wire logic        we_in,      // High for write.
  input  wire logic [15:0] addr_in,    // Holding register number.
  input  wire logic [15:0] wdata_in,   // Value to write.
  output logic             ack_out,    // One-cycle completion.
  output logic      [15:0] rdata_out   // Read value, valid with ack.
);
  logic [15:0] mem [0:4095];  // Register contents.
  int          wait_r = 0;    // Cycles the current request has waited.
  // Answers late on purpose; between answers the data toggles so stale
  // values are never mistaken for a fresh read.
  always_ff @(posedge clk_in) begin
    ack_out   <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out && wait_r >= LAT) begin
      ack_out   <= 1'b1;
      wait_r    <= 0;
      rdata_out <= mem[addr_in[11:0]];
      if (we_in) mem[addr_in[11:0]] <= wdata_in;
    end else if (req_in && !ack_out) wait_r <= wait_r + 1;
  end
endmodule : rbw_regs_mdl
`default_nettype wire

// File: rbw_handler_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Self-checking bench for the request handler.
// ************************************************************
module rbw_handler_tb;
  logic        clk_in = 0, sys_rst_in = 1, rx_valid_in = 0, rx_last_in = 0, tx_ready_in = 0;
  logic [7:0]  rx_data_in = 8'h00, tx_data_out;
  logic        rx_ready_out, tx_valid_out, tx_last_out, reg_req_out, reg_we_out, reg_ack_in;
  logic [15:0] reg_addr_out, reg_wdata_out, reg_rdata_in;
  int          n_errors = 0, comparisons = 0;
  always #2.5 clk_in = ~clk_in;
  rbw_handler dut (.clk_in, .sys_rst_in, .rx_valid_in, .rx_data_in, .rx_last_in, .rx_ready_out,
    .tx_valid_out, .tx_data_out, .tx_last_out, .tx_ready_in, .reg_req_out, .reg_we_out,
    .reg_addr_out, .reg_wdata_out, .reg_ack_in, .reg_rdata_in);
  rbw_regs_mdl #(.LAT(2)) regs (.clk_in, .req_in(reg_req_out), .we_in(reg_we_out),
    .addr_in(reg_addr_out), .wdata_in(reg_wdata_out), .ack_out(reg_ack_in),
    .rdata_out(reg_rdata_in));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Sends one frame a byte per cycle; the handler must be collecting throughout.
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(negedge clk_in);
      rx_valid_in = 1'b1;
      rx_data_in  = f[i];
      rx_last_in  = (i == f.size() - 1);
      check(rx_ready_out, 16'h0001);
    end
    @(negedge clk_in);
    rx_valid_in = 1'b0;
    rx_last_in  = 1'b0;
  endtask : send
  // Takes the response byte by byte, with a bounded wait for each one.
  task automatic expect_rsp(input logic [7:0] e[$]);
    int t;
    tx_ready_in = 1'b1;
    foreach (e[i]) begin
      t = 0;
      while (tx_valid_out !== 1'b1) begin
        @(negedge clk_in);
        if (++t > 500) begin
          check(16'h0000, 16'h0001);
          stop_test();
        end
      end
      check(tx_data_out, e[i]);
      check(tx_last_out, i == e.size() - 1);
      @(negedge clk_in);
    end
    tx_ready_in = 1'b0;
  endtask : expect_rsp
  initial begin
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
    check(tx_valid_out, 16'h0000);
    // Network address zero lands on holding register one.
    send('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h02, 8'h58});
    expect_rsp('{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02});
    check(regs.mem[1], 16'h0001);
    check(regs.mem[2], 16'h0258);
    // Combined access overlapping its own write must read the new value.
    send('{8'h5a, 8'h17, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02,
           8'h12, 8'h34});
    expect_rsp('{8'h5a, 8'h17, 8'h04, 8'h12, 8'h34, 8'h02, 8'h58});
    // Read quantity of seventeen is one too many.
    send('{8'h33, 8'h17, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02,
           8'hab, 8'hcd});
    expect_rsp('{8'h33, 8'h97, 8'h03});
    // Byte count disagreeing with the write quantity must write nothing.
    send('{8'h44, 8'h17, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04,
           8'h99, 8'h99, 8'h99, 8'h99});
    expect_rsp('{8'h44, 8'h97, 8'h03});
    check(regs.mem[1], 16'h1234);
    // Zero registers in a write-multiple request.
    send('{8'h02, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    expect_rsp('{8'h02, 8'h90, 8'h03});
    // Spans running past the last register in either function.
    send('{8'h07, 8'h10, 8'h0f, 8'hff, 8'h00, 8'h02, 8'h04, 8'h11, 8'h11, 8'h22, 8'h22});
    expect_rsp('{8'h07, 8'h90, 8'h02});
    send('{8'h08, 8'h17, 8'h0f, 8'hff, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02,
           8'h00, 8'h00});
    expect_rsp('{8'h08, 8'h97, 8'h02});
    stop_test();
  end
endmodule : rbw_handler_tb
`default_nettype wire
